//--- logic/pfc_pkg.sv
package pfc_pkg;

  // Datapath widths.
  localparam int unsigned PFC_ACC_W   = 32;
  localparam int unsigned PFC_HALF_W  = 16;
  localparam int unsigned PFC_PHASE_W = 16;
  localparam int unsigned PFC_QPSK_W  = 2;
  localparam int unsigned PFC_PAD_W   = 14;

  // Field positions inside the 32-bit words.
  localparam int unsigned PFC_ARG_MSB  = 31;
  localparam int unsigned PFC_TOP_LSB  = 16;
  localparam int unsigned PFC_HIGH_LSB = 16;

  // Register select codes on the host word port.
  localparam logic [1:0] PFC_SEL_FREQ_LOW  = 2'h0;
  localparam logic [1:0] PFC_SEL_FREQ_HIGH = 2'h1;
  localparam logic [1:0] PFC_SEL_PHASE     = 2'h2;

  // Reset values.
  localparam logic [15:0] PFC_HALF_RST  = 16'h0000;
  localparam logic [31:0] PFC_WORD_RST  = 32'h0000_0000;
  localparam logic [15:0] PFC_PHASE_RST = 16'h0000;
  localparam logic        PFC_ENQ_RST   = 1'b1;
  localparam logic        PFC_CARRY_RST = 1'b1;

endpackage : pfc_pkg

//--- logic/pfc_accum.sv
`timescale 1ns/1ps

module pfc_accum
  import pfc_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  input  wire logic                 clk_en,
  // Step and feedback control.
  input  wire logic [PFC_ACC_W-1:0] incr,
  input  wire logic                 init_n,
  // Accumulator state and carry.
  output logic      [PFC_ACC_W-1:0] acc_q,
  output logic                      carry_n
);

  logic [PFC_ACC_W-1:0] acc_reg;
  logic [PFC_ACC_W-1:0] acc_next;
  logic                 carry_reg;
  logic                 carry_next;
  logic [PFC_ACC_W-1:0] feedback;
  logic [PFC_ACC_W:0]   sum;

  // Zeroed feedback also makes an overflow impossible on that edge.
  always_comb begin
    feedback   = init_n ? acc_reg : PFC_WORD_RST;
    sum        = {1'b0, feedback} + {1'b0, incr};
    acc_next   = sum[PFC_ACC_W-1:0];
    carry_next = ~sum[PFC_ACC_W];
    if (!clk_en) begin
      acc_next   = acc_reg;
      carry_next = carry_reg;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      acc_reg   <= PFC_WORD_RST;
      carry_reg <= PFC_CARRY_RST;
    end else begin
      acc_reg   <= acc_next;
      carry_reg <= carry_next;
    end
  end

  assign acc_q   = acc_reg;
  assign carry_n = carry_reg;

endmodule : pfc_accum

//--- logic/pfc_top.sv
`timescale 1ns/1ps


module pfc_top
  import pfc_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic                   core_clk,
  input  wire logic                   rstn,
  input  wire logic                   clk_en,
  // Host word port.
  input  wire logic [PFC_HALF_W-1:0]  host_word,
  input  wire logic [1:0]             reg_select,
  input  wire logic                   cs_n,
  input  wire logic                   wr_n,
  // Register load enables.
  input  wire logic                   center_freq_enable_n,
  input  wire logic                   offset_freq_enable_n,
  input  wire logic                   phase_enable_n,
  input  wire logic                   time_incr_enable_n,
  // Phase source and modulation.
  input  wire logic                   phase_source_sel,
  input  wire logic [PFC_QPSK_W-1:0]  qpsk_select,
  input  wire logic                   offset_suppress_n,
  input  wire logic                   phase_range_sel,
  // Accumulator initialise controls.
  input  wire logic                   acc_init_n,
  input  wire logic                   time_acc_init_n,
  // Results.
  output logic      [PFC_ACC_W-1:0]   sincos_arg,
  output logic                        phase_carry_out_n,
  output logic                        time_carry_out_n
);

  import pfc_pkg::*;

  // Decodes one strobe of the host port for a given register code.
  function automatic logic host_hit(input logic       cs_l,
                                    input logic       wr_l,
                                    input logic [1:0] sel,
                                    input logic [1:0] code);
    host_hit = !cs_l && !wr_l && (sel == code);
  endfunction : host_hit

  // Modulation code to phase word. Only the top two bits are ever set,
  // so the pad below them is always zero.
  function automatic logic [PFC_PHASE_W-1:0] qpsk_angle(
      input logic [PFC_QPSK_W-1:0] code);
    logic [1:0] top;
    top        = {code[1], code[1] ^ code[0]};
    qpsk_angle = {top, {PFC_PAD_W{1'b0}}};
  endfunction : qpsk_angle

  // Modulo pi folds the upper half circle onto the lower one, so the
  // lookup never sees an angle past 180 degrees.
  function automatic logic [PFC_ACC_W-1:0] limit_range(
      input logic [PFC_ACC_W-1:0] arg,
      input logic                 half);
    limit_range = arg;
    if (half) begin
      limit_range[PFC_ARG_MSB] = 1'b0;
    end
  endfunction : limit_range

  // Host input registers.
  logic [PFC_HALF_W-1:0]  freq_input_low_half_reg;
  logic [PFC_HALF_W-1:0]  freq_input_low_half_next;
  logic [PFC_HALF_W-1:0]  freq_input_high_half_reg;
  logic [PFC_HALF_W-1:0]  freq_input_high_half_next;
  logic [PFC_PHASE_W-1:0] phase_offset_input_reg;
  logic [PFC_PHASE_W-1:0] phase_offset_input_next;
  logic [PFC_ACC_W-1:0]   input_word;
  logic                   load_low;
  logic                   load_high;
  logic                   load_phase;

  // Registered load enables.
  logic center_freq_enable_q_reg;
  logic center_freq_enable_q_next;
  logic offset_freq_enable_q_reg;
  logic offset_freq_enable_q_next;
  logic phase_enable_q_reg;
  logic phase_enable_q_next;

  // Frequency and time step registers.
  logic [PFC_ACC_W-1:0]   center_freq_reg;
  logic [PFC_ACC_W-1:0]   center_freq_next;
  logic [PFC_ACC_W-1:0]   offset_freq_reg;
  logic [PFC_ACC_W-1:0]   offset_freq_next;
  logic [PFC_ACC_W-1:0]   time_incr_reg;
  logic [PFC_ACC_W-1:0]   time_incr_next;

  // Phase register and its modulation source.
  logic [PFC_PHASE_W-1:0] phase_reg;
  logic [PFC_PHASE_W-1:0] phase_next;
  logic [PFC_PHASE_W-1:0] qpsk_phase;

  // Accumulator datapath.
  logic [PFC_ACC_W-1:0]   offset_term;
  logic [PFC_ACC_W-1:0]   phase_step;
  logic [PFC_ACC_W-1:0]   phase_acc;
  logic [PFC_ACC_W-1:0]   sincos_arg_reg;
  logic [PFC_ACC_W-1:0]   sincos_arg_next;
  logic [PFC_PHASE_W-1:0] arg_top;
  logic [PFC_ACC_W-1:0]   arg_word;

  // One strobe per register code; code 11 and a high chip select store
  // nothing, since no strobe decodes them.
  assign load_low   = host_hit(cs_n, wr_n, reg_select, PFC_SEL_FREQ_LOW);
  assign load_high  = host_hit(cs_n, wr_n, reg_select, PFC_SEL_FREQ_HIGH);
  assign load_phase = host_hit(cs_n, wr_n, reg_select, PFC_SEL_PHASE);

  // Host input register group.
  always_comb begin
    freq_input_low_half_next  = freq_input_low_half_reg;
    freq_input_high_half_next = freq_input_high_half_reg;
    phase_offset_input_next   = phase_offset_input_reg;
    if (clk_en) begin
      if (load_low) begin
        freq_input_low_half_next = host_word;
      end
      if (load_high) begin
        freq_input_high_half_next = host_word;
      end
      if (load_phase) begin
        phase_offset_input_next = host_word;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      freq_input_low_half_reg  <= PFC_HALF_RST;
      freq_input_high_half_reg <= PFC_HALF_RST;
      phase_offset_input_reg   <= PFC_PHASE_RST;
    end else begin
      freq_input_low_half_reg  <= freq_input_low_half_next;
      freq_input_high_half_reg <= freq_input_high_half_next;
      phase_offset_input_reg   <= phase_offset_input_next;
    end
  end

  // The two halves are only meaningful together as one load word.
  assign input_word = {freq_input_high_half_reg,
                       freq_input_low_half_reg};

  // Enable registering group.
  always_comb begin
    center_freq_enable_q_next = center_freq_enable_q_reg;
    offset_freq_enable_q_next = offset_freq_enable_q_reg;
    phase_enable_q_next       = phase_enable_q_reg;
    if (clk_en) begin
      center_freq_enable_q_next = center_freq_enable_n;
      offset_freq_enable_q_next = offset_freq_enable_n;
      phase_enable_q_next       = phase_enable_n;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      center_freq_enable_q_reg <= PFC_ENQ_RST;
      offset_freq_enable_q_reg <= PFC_ENQ_RST;
      phase_enable_q_reg       <= PFC_ENQ_RST;
    end else begin
      center_freq_enable_q_reg <= center_freq_enable_q_next;
      offset_freq_enable_q_reg <= offset_freq_enable_q_next;
      phase_enable_q_reg       <= phase_enable_q_next;
    end
  end

  // Frequency step group.
  always_comb begin
    center_freq_next = center_freq_reg;
    offset_freq_next = offset_freq_reg;
    if (clk_en) begin
      // A held enable keeps reloading, so halves written meanwhile follow.
      if (!center_freq_enable_q_reg) begin
        center_freq_next = input_word;
      end
      if (!offset_freq_enable_q_reg) begin
        offset_freq_next = input_word;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      center_freq_reg <= PFC_WORD_RST;
      offset_freq_reg <= PFC_WORD_RST;
    end else begin
      center_freq_reg <= center_freq_next;
      offset_freq_reg <= offset_freq_next;
    end
  end

  // Time step group. Its enable is used unregistered, unlike the
  // frequency enables, so the step loads on the edge that samples it low.
  always_comb begin
    time_incr_next = time_incr_reg;
    if (clk_en && !time_incr_enable_n) begin
      time_incr_next = input_word;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      time_incr_reg <= PFC_WORD_RST;
    end else begin
      time_incr_reg <= time_incr_next;
    end
  end

  // Phase register group.
  // The top two bits follow the modulation code so that 10 lands on 270
  // degrees and 11 on 180, with the higher input still the MSB.
  always_comb begin
    qpsk_phase = qpsk_angle(qpsk_select);
    phase_next = phase_reg;
    if (clk_en && !phase_enable_q_reg) begin
      if (phase_source_sel) begin
        phase_next = phase_offset_input_reg;
      end else begin
        phase_next = qpsk_phase;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      phase_reg <= PFC_PHASE_RST;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // Phase step: the offset is masked, not cleared, so it returns intact.
  always_comb begin
    offset_term = PFC_WORD_RST;
    if (offset_suppress_n) begin
      offset_term = offset_freq_reg;
    end
    phase_step  = center_freq_reg + offset_term;
  end

  // Phase accumulator, carry inverted onto the pin.
  pfc_accum u_phase_acc (
    .core_clk (core_clk),
    .rstn     (rstn),
    .clk_en   (clk_en),
    .incr     (phase_step),
    .init_n   (acc_init_n),
    .acc_q    (phase_acc),
    .carry_n  (phase_carry_out_n)
  );

  // Time accumulator, whose carry is its only output.
  pfc_accum u_time_acc (
    .core_clk (core_clk),
    .rstn     (rstn),
    .clk_en   (clk_en),
    .incr     (time_incr_reg),
    .init_n   (time_acc_init_n),
    .acc_q    (),
    .carry_n  (time_carry_out_n)
  );

  // Argument group: offset added to the top half, then range limited.
  // Registering the argument costs a cycle but keeps the adder off the pin.
  always_comb begin
    arg_top         = phase_acc[PFC_ARG_MSB:PFC_TOP_LSB] + phase_reg;
    arg_word        = {arg_top, phase_acc[PFC_TOP_LSB-1:0]};
    sincos_arg_next = limit_range(arg_word, phase_range_sel);
    if (!clk_en) begin
      sincos_arg_next = sincos_arg_reg;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sincos_arg_reg <= PFC_WORD_RST;
    end else begin
      sincos_arg_reg <= sincos_arg_next;
    end
  end

  assign sincos_arg = sincos_arg_reg;

endmodule : pfc_top

//--- tb/pfc_checker.sv
`timescale 1ns/1ps

module pfc_checker
  import pfc_pkg::*;
(
  // Clock and reset.
  input wire logic                 core_clk,
  input wire logic                 rstn,
  // Watched inputs.
  input wire logic                 clk_en,
  input wire logic                 center_freq_enable_n,
  input wire logic                 offset_freq_enable_n,
  input wire logic                 offset_suppress_n,
  input wire logic                 phase_range_sel,
  input wire logic                 acc_init_n,
  input wire logic                 time_acc_init_n,
  // Watched outputs.
  input wire logic [PFC_ACC_W-1:0] sincos_arg,
  input wire logic                 phase_carry_out_n,
  input wire logic                 time_carry_out_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // The step is unknown here, so a double restart must double it.
  wire quiet = clk_en && center_freq_enable_n && offset_freq_enable_n;

  sequence restart_s;
    quiet ##1 (quiet && !acc_init_n && $stable(offset_suppress_n))[*2]
    ##1 (quiet && acc_init_n && $stable(offset_suppress_n)) ##1 clk_en;
  endsequence

  restart_double_a: assert property (restart_s |=>
    sincos_arg[15:0] == {$past(sincos_arg[14:0]), 1'b0})
    else $error("Restart did not double the step");
  freeze_arg_a: assert property (!clk_en |=> $stable(sincos_arg))
    else $error("Argument moved while frozen");
  freeze_carry_a: assert property (!clk_en |=>
    $stable(phase_carry_out_n) && $stable(time_carry_out_n))
    else $error("Carry moved while frozen");
  init_phase_a: assert property (!acc_init_n && clk_en |=>
    phase_carry_out_n) else $error("Phase carry during initialise");
  init_time_a: assert property (!time_acc_init_n && clk_en |=>
    time_carry_out_n) else $error("Time carry during initialise");
  range_half_a: assert property (phase_range_sel && clk_en |=>
    !sincos_arg[PFC_ARG_MSB]) else $error("Half range bit set");
  phase_cause_a: assert property ($fell(phase_carry_out_n) |->
    $past(clk_en) && $past(acc_init_n))
    else $error("Phase carry without accumulation");
  time_cause_a: assert property ($fell(time_carry_out_n) |->
    $past(clk_en) && $past(time_acc_init_n))
    else $error("Time carry without accumulation");
endmodule : pfc_checker

bind pfc_top pfc_checker u_chk (.core_clk, .rstn, .clk_en,
  .center_freq_enable_n, .offset_freq_enable_n, .offset_suppress_n,
  .phase_range_sel, .acc_init_n, .time_acc_init_n, .sincos_arg,
  .phase_carry_out_n, .time_carry_out_n);

//--- tb/pfc_host.sv
`timescale 1ns/1ps

module pfc_host
  import pfc_pkg::*;
(
  // Host bus pins.
  output logic [PFC_HALF_W-1:0] host_word,
  output logic [1:0]            reg_select,
  output logic                  cs_n,
  output logic                  wr_n
);
  initial begin
    {cs_n, wr_n, reg_select} = 4'hc;
    host_word = 16'h5a5a;
  end

  // A deselected bus must not keep showing the last word, so it flips.
  task automatic put(input logic cs, wr, input logic [1:0] sel,
                     input logic [15:0] w);
    cs_n = cs;
    wr_n = wr;
    reg_select = sel;
    host_word = cs ? ~host_word : w;
  endtask : put

  function automatic logic [31:0] time_step(input int unsigned per, ival);
    return 32'((64'h1_0000_0000 * per) / ival);
  endfunction : time_step
endmodule : pfc_host

//--- tb/pfc_top_tb.sv
`timescale 1ns/1ps

module pfc_top_tb;
  import pfc_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en, center_freq_enable_n, offset_freq_enable_n, phase_enable_n;
  logic time_incr_enable_n, phase_source_sel, offset_suppress_n;
  logic phase_range_sel, acc_init_n, time_acc_init_n;
  logic [1:0] qpsk_select;
  wire logic [PFC_HALF_W-1:0] host_word;
  wire logic [1:0] reg_select;
  wire logic cs_n, wr_n, phase_carry_out_n, time_carry_out_n;
  wire logic [PFC_ACC_W-1:0] sincos_arg;
  logic [15:0] m_lo, m_hi, m_pin, m_ph;
  logic [31:0] m_cen, m_off, m_ts, m_acc, m_tacc, m_arg, r;
  logic m_cq, m_oq, m_pq, m_pc, m_tc;
  int n_mismatch = 0;
  int cmp_count = 0;

  always #4 core_clk = ~core_clk;

  pfc_host host (.host_word, .reg_select, .cs_n, .wr_n);
  pfc_top uut (.core_clk, .rstn, .clk_en, .host_word, .reg_select, .cs_n,
    .wr_n, .center_freq_enable_n, .offset_freq_enable_n, .phase_enable_n,
    .time_incr_enable_n, .phase_source_sel, .qpsk_select,
    .offset_suppress_n, .phase_range_sel, .acc_init_n, .time_acc_init_n,
    .sincos_arg, .phase_carry_out_n, .time_carry_out_n);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [15:0] phase_of(input logic src,
      input logic [15:0] pin, input logic [1:0] q);
    return src ? pin : {q[1], q[1] ^ q[0], 14'h0};
  endfunction : phase_of

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      {m_lo, m_hi, m_pin, m_ph} <= '0;
      {m_cen, m_off, m_ts, m_acc, m_tacc, m_arg} <= '0;
      {m_cq, m_oq, m_pq, m_pc, m_tc} <= 5'h1c;
    end else if (clk_en) begin
      if (!cs_n && !wr_n) begin
        case (reg_select)
          2'h0: m_lo <= host_word;
          2'h1: m_hi <= host_word;
          2'h2: m_pin <= host_word;
          default: ;
        endcase
      end
      {m_cq, m_oq, m_pq} <= {center_freq_enable_n, offset_freq_enable_n,
                             phase_enable_n};
      if (!m_cq) m_cen <= {m_hi, m_lo};
      if (!m_oq) m_off <= {m_hi, m_lo};
      if (!m_pq) m_ph <= phase_of(phase_source_sel, m_pin, qpsk_select);
      if (!time_incr_enable_n) m_ts <= {m_hi, m_lo};
      {m_pc, m_acc} <= {1'b0, acc_init_n ? m_acc : 32'h0} +
        {1'b0, m_cen + (offset_suppress_n ? m_off : 32'h0)};
      {m_tc, m_tacc} <= {1'b0, time_acc_init_n ? m_tacc : 32'h0} +
        {1'b0, m_ts};
      m_arg <= {m_acc[31:16] + m_ph, m_acc[15:0]} &
        {~phase_range_sel, 31'h7fffffff};
    end
  end

  task automatic chk(input string name, input logic [31:0] e, got);
    cmp_count++;
    if (got !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, e, got);
    end
  endtask : chk

  always @(posedge core_clk) begin
    #3;
    chk("sincos_arg", m_arg, sincos_arg);
    chk("phase_carry_out_n", {31'h0, ~m_pc}, {31'h0, phase_carry_out_n});
    chk("time_carry_out_n", {31'h0, ~m_tc}, {31'h0, time_carry_out_n});
  end

  task automatic finish_test();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic wr32(input logic [31:0] w);
    host.put(1'b0, 1'b0, 2'h0, w[15:0]);
    tick(1);
    host.put(1'b0, 1'b0, 2'h1, w[31:16]);
    tick(1);
    host.put(1'b1, 1'b1, 2'h0, 16'h0);
    tick(1);
  endtask : wr32

  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    {clk_en, center_freq_enable_n, offset_freq_enable_n, phase_enable_n,
     time_incr_enable_n, phase_source_sel, offset_suppress_n, acc_init_n,
     time_acc_init_n} = 9'h1ff;
    {phase_range_sel, qpsk_select} = 3'h0;
    r = 32'he3d2e66d;
    tick(16);
    rstn = 1'b1;
    wr32(32'h0000_0001);
    host.put(1'b0, 1'b0, 2'h3, 16'hffff);
    tick(1);
    host.put(1'b1, 1'b0, 2'h0, 16'hffff);
    center_freq_enable_n = 1'b0;
    tick(1);
    center_freq_enable_n = 1'b1;
    acc_init_n = 1'b0;
    tick(3);
    acc_init_n = 1'b1;
    tick(20);
    wr32(32'h8000_0000);
    offset_freq_enable_n = 1'b0;
    tick(1);
    offset_freq_enable_n = 1'b1;
    tick(6);
    {offset_suppress_n, phase_range_sel} = 2'h1;
    tick(6);
    {offset_suppress_n, phase_range_sel} = 2'h2;
    wr32(host.time_step(8, 64));
    {time_incr_enable_n, time_acc_init_n} = 2'h0;
    tick(1);
    {time_incr_enable_n, time_acc_init_n} = 2'h3;
    tick(24);
    {phase_source_sel, phase_enable_n} = 2'h0;
    for (int q = 0; q < 4; q++) begin
      qpsk_select = 2'(q);
      tick(2);
    end
    // Random traffic; one mid-run reset checks the reset values again.
    for (int i = 0; i < 2000; i++) begin
      r = lfsr(r);
      {clk_en, center_freq_enable_n, offset_freq_enable_n} =
        {|r[2:0], |r[4:3], |r[6:5]};
      {phase_enable_n, time_incr_enable_n, acc_init_n, time_acc_init_n} =
        {|r[8:7], |r[10:9], |r[12:11], |r[14:13]};
      offset_suppress_n = r[15];
      r = lfsr(r);
      {phase_range_sel, phase_source_sel, qpsk_select} = r[3:0];
      host.put(r[4], r[5], r[7:6], r[31:16]);
      rstn = (i != 1000);
      tick(1);
    end
    finish_test();
  end
endmodule : pfc_top_tb
